// File: spio_top.sv
// Control of the interrupt and frame-sync open-drain pins
// Functional notes
// - Interrupt polarity flip bit 6 inverts every source routed to the interrupt pin.
// - Interrupt input select bit 5 releases the interrupt pin for input use.
// - Read-only bit 4 returns the level seen on the interrupt pin.
// - Frame-sync polarity flip bit 3 inverts every source routed to that pin.
// - Frame-sync input select bit 2 releases the frame-sync pin for input use.
// - Frame-sync drive bit 1 sets low or released; resets to one.
// - Frame-sync source map chooses the internal signal driving that pin.
// - Read-only bit 0 returns the level seen on the frame-sync pin.
// - Trigger choice picks frame-sync pin at zero, interrupt pin at one.
`timescale 1ns/1ps
`include "spio_map.svh"
module spio_top
   import spio_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic i_irq_source,
   input wire logic [1:0] i_irq_pin_source_map,
   input wire logic i_sync_event,
   input wire logic [1:0] i_sync_pin_source_map,
   input wire logic i_trigger_pin_sel,
   input wire logic i_irq_pin_in,
   output logic o_irq_pin_out,
   output logic o_irq_pin_oe,
   input wire logic i_sync_pin_in,
   output logic o_sync_pin_out,
   output logic o_sync_pin_oe,
   output logic o_ext_trigger,
   output logic o_irq_level,
   output logic o_sync_level
);
   logic irq_inv_r, irq_inv_nxt;
   logic irq_isel_r, irq_isel_nxt;
   logic sync_inv_r, sync_inv_nxt;
   logic sync_isel_r, sync_isel_nxt;
   logic sync_drv_r, sync_drv_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   spio_state_t state_r, state_nxt;
   logic irq_lvl, sync_lvl;
   logic irq_raw, sync_raw;
   logic irq_oe_r, irq_oe_nxt, sync_oe_r, sync_oe_nxt;
   logic trig_r, trig_nxt, irq_lvl_r, sync_lvl_r;
   logic hit;

   // Pin levels are asynchronous to our clock
   spio_sync u_irq_sync (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_async(i_irq_pin_in),
      .o_sync(irq_lvl)
   );
   spio_sync u_sync_sync (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_async(i_sync_pin_in),
      .o_sync(sync_lvl)
   );

   assign hit = (i_reg_addr == `SPIO_ADDR_PIN_IO_CONTROL);

   // Register writes and read data; bit 7 is never stored
   always_comb begin
      irq_inv_nxt = irq_inv_r;
      irq_isel_nxt = irq_isel_r;
      sync_inv_nxt = sync_inv_r;
      sync_isel_nxt = sync_isel_r;
      sync_drv_nxt = sync_drv_r;
      rdata_nxt = rdata_r;
      state_nxt = state_r;
      case (state_r)
         SPIO_ST_IDLE: begin
            if (i_reg_wr && hit) begin
               irq_inv_nxt = i_reg_wdata[`SPIO_BIT_IRQ_INVERT];
               irq_isel_nxt = i_reg_wdata[`SPIO_BIT_IRQ_IN_SEL];
               sync_inv_nxt = i_reg_wdata[`SPIO_BIT_SYNC_INVERT];
               sync_isel_nxt = i_reg_wdata[`SPIO_BIT_SYNC_IN_SEL];
               sync_drv_nxt = i_reg_wdata[`SPIO_BIT_SYNC_DRIVE];
            end
            if (i_reg_rd) begin
               rdata_nxt = 8'h00; // Unmapped and reserved read zero
               if (hit) begin
                  rdata_nxt[`SPIO_BIT_IRQ_INVERT] = irq_inv_r;
                  rdata_nxt[`SPIO_BIT_IRQ_IN_SEL] = irq_isel_r;
                  rdata_nxt[`SPIO_BIT_IRQ_LEVEL] = irq_lvl;
                  rdata_nxt[`SPIO_BIT_SYNC_INVERT] = sync_inv_r;
                  rdata_nxt[`SPIO_BIT_SYNC_IN_SEL] = sync_isel_r;
                  rdata_nxt[`SPIO_BIT_SYNC_DRIVE] = sync_drv_r;
                  rdata_nxt[`SPIO_BIT_SYNC_LEVEL] = sync_lvl;
               end
               state_nxt = SPIO_ST_HOLD;
            end
         end
         SPIO_ST_HOLD: begin
            // Read data stands until the strobe drops
            if (!i_reg_rd) begin
               state_nxt = SPIO_ST_IDLE;
            end
         end
         default: begin
            state_nxt = SPIO_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_inv_r <= `SPIO_RST_IRQ_INVERT;
         irq_isel_r <= `SPIO_RST_IRQ_IN_SEL;
         sync_inv_r <= `SPIO_RST_SYNC_INVERT;
         sync_isel_r <= `SPIO_RST_SYNC_IN_SEL;
         sync_drv_r <= `SPIO_RST_SYNC_DRIVE;
         rdata_r <= 8'h00;
         state_r <= SPIO_ST_IDLE;
      end else begin
         irq_inv_r <= irq_inv_nxt;
         irq_isel_r <= irq_isel_nxt;
         sync_inv_r <= sync_inv_nxt;
         sync_isel_r <= sync_isel_nxt;
         sync_drv_r <= sync_drv_nxt;
         rdata_r <= rdata_nxt;
         state_r <= state_nxt;
      end
   end

   // Source selection and polarity; open drain only ever pulls low
   always_comb begin
      irq_raw = i_irq_source;
      if (i_irq_pin_source_map == 2'h1) begin
         irq_raw = i_sync_event;
      end
      irq_raw = irq_raw ^ irq_inv_r;
      case (spio_src_t'(i_sync_pin_source_map))
         SPIO_SRC_LEVEL: sync_raw = sync_drv_r;
         SPIO_SRC_EVENT: sync_raw = i_sync_event;
         SPIO_SRC_IRQ: sync_raw = i_irq_source;
         SPIO_SRC_LOW: sync_raw = 1'b0;
         default: sync_raw = sync_drv_r;
      endcase
      sync_raw = sync_raw ^ sync_inv_r;
      irq_oe_nxt = !irq_isel_r && !irq_raw;
      sync_oe_nxt = !sync_isel_r && !sync_raw;
      trig_nxt = i_trigger_pin_sel ? irq_lvl : sync_lvl;
   end

   // Registered pin drive; enables start released after reset
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_oe_r <= 1'b0;
         sync_oe_r <= 1'b0;
         trig_r <= 1'b0;
         irq_lvl_r <= 1'b0;
         sync_lvl_r <= 1'b0;
      end else begin
         irq_oe_r <= irq_oe_nxt;
         sync_oe_r <= sync_oe_nxt;
         trig_r <= trig_nxt;
         irq_lvl_r <= irq_lvl;
         sync_lvl_r <= sync_lvl;
      end
   end

   assign o_reg_rdata = rdata_r;
   assign o_irq_pin_out = 1'b0;
   assign o_irq_pin_oe = irq_oe_r;
   assign o_sync_pin_out = 1'b0;
   assign o_sync_pin_oe = sync_oe_r;
   assign o_ext_trigger = trig_r;
   assign o_irq_level = irq_lvl_r;
   assign o_sync_level = sync_lvl_r;

   // Checks; pin drive is registered, so each consequent looks one edge after its cause
   a_irq_in_release: assert property (@(posedge i_clock) disable iff (!i_nrst)
      irq_isel_r |=> !o_irq_pin_oe) else $error("irq pin driven in input mode");
   a_sync_in_release: assert property (@(posedge i_clock) disable iff (!i_nrst)
      sync_isel_r |=> !o_sync_pin_oe) else $error("sync pin driven in input mode");
   a_irq_invert_map: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (!irq_isel_r && i_irq_pin_source_map == 2'h0) |=>
      o_irq_pin_oe == ($past(i_irq_source) == $past(irq_inv_r))) else $error("irq polarity wrong");
   a_irq_event_map: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (!irq_isel_r && i_irq_pin_source_map == 2'h1) |=>
      o_irq_pin_oe == ($past(i_sync_event) == $past(irq_inv_r))) else $error("irq event polarity wrong");
   a_sync_drive_lvl: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (!sync_isel_r && i_sync_pin_source_map == 2'h0) |=>
      o_sync_pin_oe == ($past(sync_drv_r) == $past(sync_inv_r))) else $error("sync drive wrong");
   a_sync_src_low: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (!sync_isel_r && !sync_inv_r && i_sync_pin_source_map == 2'h3) |=> o_sync_pin_oe)
      else $error("sync low source not driven");
   // Status bits report the synchronised level, never the raw pin
   a_irq_level_read: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (i_reg_rd && hit && state_r == SPIO_ST_IDLE) |=> o_reg_rdata[4] == $past(irq_lvl))
      else $error("irq level read wrong");
   a_sync_level_read: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (i_reg_rd && hit && state_r == SPIO_ST_IDLE) |=> o_reg_rdata[0] == $past(sync_lvl))
      else $error("sync level read wrong");
   a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !o_reg_rdata[7]) else $error("reserved bit set");
   a_trigger_pick: assert property (@(posedge i_clock) disable iff (!i_nrst)
      i_trigger_pin_sel |=> o_ext_trigger == $past(irq_lvl)) else $error("trigger pick wrong");
   a_trigger_sync_pick: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !i_trigger_pin_sel |=> o_ext_trigger == $past(sync_lvl)) else $error("trigger sync pick wrong");
   // A single flop would show the new level one cycle early
   a_sync_two_flop: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(i_sync_pin_in) |=> !sync_lvl ##1 sync_lvl) else $error("sync level lag wrong");
   a_irq_two_flop: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(i_irq_pin_in) |=> !irq_lvl ##1 irq_lvl) else $error("irq level lag wrong");
   // Scenarios the bench is expected to reach
   c_irq_input: cover property (@(posedge i_clock) disable iff (!i_nrst) irq_isel_r && irq_lvl);
   c_sync_pulled: cover property (@(posedge i_clock) disable iff (!i_nrst) sync_isel_r && !sync_lvl);
   c_sync_driven: cover property (@(posedge i_clock) disable iff (!i_nrst) o_sync_pin_oe);
   c_inverted: cover property (@(posedge i_clock) disable iff (!i_nrst) irq_inv_r && o_irq_pin_oe);
   c_read: cover property (@(posedge i_clock) disable iff (!i_nrst) i_reg_rd && hit);
endmodule

// File: spio_map.svh
// Register offsets, field positions, reset values and timing for the pin control block
`ifndef SPIO_MAP_SVH
`define SPIO_MAP_SVH
`define SPIO_ADDR_PIN_IO_CONTROL 8'hf8
`define SPIO_BIT_IRQ_INVERT 6
`define SPIO_BIT_IRQ_IN_SEL 5
`define SPIO_BIT_IRQ_LEVEL 4
`define SPIO_BIT_SYNC_INVERT 3
`define SPIO_BIT_SYNC_IN_SEL 2
`define SPIO_BIT_SYNC_DRIVE 1
`define SPIO_BIT_SYNC_LEVEL 0
`define SPIO_RST_IRQ_INVERT 1'b0
`define SPIO_RST_IRQ_IN_SEL 1'b0
`define SPIO_RST_SYNC_INVERT 1'b0
`define SPIO_RST_SYNC_IN_SEL 1'b0
`define SPIO_RST_SYNC_DRIVE 1'b1
`define SPIO_SYNC_STAGES 2
`endif

// File: spio_pkg.sv
// Types shared by the pin control block
package spio_pkg;
   // Source choice for the frame-sync pin output
   typedef enum logic [1:0] {
      SPIO_SRC_LEVEL = 2'h0,
      SPIO_SRC_EVENT = 2'h1,
      SPIO_SRC_IRQ = 2'h2,
      SPIO_SRC_LOW = 2'h3
   } spio_src_t;
   // Register access state, one-hot
   typedef enum logic [1:0] {
      SPIO_ST_IDLE = 2'b01,
      SPIO_ST_HOLD = 2'b10
   } spio_state_t;
endpackage

// File: spio_sync.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module spio_sync (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_async,
   output logic o_sync
);
   logic meta_r;
   logic meta_nxt;
   logic sync_r;
   logic sync_nxt;
   // Second stage alone reads the first
   always_comb begin
      meta_nxt = i_async;
      sync_nxt = meta_r;
   end
   // Reset to low; pins are pulled up so first samples settle in two cycles
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end
   assign o_sync = sync_r;
endmodule

// File: spio_host_model.sv
// Far side of the two open-drain pins: pull-up network and host pull-down drivers
`timescale 1ns/1ps
module spio_host_model (
   input wire logic i_irq_oe,
   input wire logic i_sync_oe,
   input wire logic i_host_irq_pull,
   input wire logic i_host_sync_pull,
   output logic o_irq_wire,
   output logic o_sync_wire
);
   // Wired-and of every driver; the pull-up keeps an input net defined, never floating
   assign o_irq_wire = ~(i_irq_oe | i_host_irq_pull);
   assign o_sync_wire = ~(i_sync_oe | i_host_sync_pull);
endmodule

// File: testbench.sv
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
   // Interrupt source idles high so the pin starts released and reads back high
   logic clk = 0, nrst = 0, wr = 0, rd = 0, isrc = 1, sev = 0, tsel = 0, hp_irq = 0, hp_sync = 0, e;
   logic ipo, spo;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdv;
   logic [1:0] imap = 2'h0, smap = 2'h0;
   logic irq_w, sync_w, irq_oe, sync_oe, trig, il, sl;
   logic [7:0] rdata;
   int n_fail = 0, checks_done = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   spio_top dut (.i_clock(clk), .i_nrst(nrst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_irq_source(isrc), .i_irq_pin_source_map(imap),
      .i_sync_event(sev), .i_sync_pin_source_map(smap), .i_trigger_pin_sel(tsel),
      .i_irq_pin_in(irq_w), .o_irq_pin_out(ipo), .o_irq_pin_oe(irq_oe), .i_sync_pin_in(sync_w),
      .o_sync_pin_out(spo), .o_sync_pin_oe(sync_oe), .o_ext_trigger(trig), .o_irq_level(il),
      .o_sync_level(sl));
   spio_host_model host (.i_irq_oe(irq_oe), .i_sync_oe(sync_oe), .i_host_irq_pull(hp_irq),
      .i_host_sync_pull(hp_sync), .o_irq_wire(irq_w), .o_sync_wire(sync_w));
   // Write, then let the pin drivers settle
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk); wr = 1; addr = a; wd = d;
      @(negedge clk); wr = 0;
      repeat (3) @(negedge clk);
   endtask
   // Strobe drops before the data is taken, so reads never run together
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
      @(negedge clk); rd = 1; addr = a;
      @(negedge clk); rd = 0;
      @(negedge clk); q = rdata;
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Hang guard, well above the few hundred cycles the tests need
   initial begin
      #(50 * 4000);
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      give_verdict();
   end
   initial begin
      repeat (2) @(negedge clk); nrst = 1;
      repeat (3) @(negedge clk);
      rd_reg(8'hf8, rdv); `CHK(rdv, 8'h13)
      `CHK(sync_oe, 1'b0)
      `CHK(spo, 1'b0)
      `CHK(ipo, 1'b0)
      $display("test reset done");
      // Inputs selected, sources would otherwise pull both pins low
      isrc = 1;
      wr_reg(8'hf8, 8'hff); rd_reg(8'hf8, rdv); `CHK(rdv, 8'h7f)
      `CHK(irq_oe, 1'b0)
      `CHK(sync_oe, 1'b0)
      wr_reg(8'hf7, 8'h00); rd_reg(8'hf8, rdv); `CHK(rdv, 8'h7f)
      rd_reg(8'hf7, rdv); `CHK(rdv, 8'h00)
      $display("test reserved and decode done");
      // Every interrupt source map and polarity
      for (int m = 0; m < 4; m++) for (int v = 0; v < 4; v++) begin
         wr_reg(8'hf8, {1'b0, v[1], 6'h02});
         imap = m[1:0]; isrc = v[0]; sev = ~v[0];
         repeat (3) @(negedge clk);
         e = ~(((m == 1) ? ~v[0] : v[0]) ^ v[1]);
         `CHK(irq_oe, e)
      end
      $display("test interrupt pin done");
      // Every frame-sync source map and polarity, interrupt pin released
      for (int m = 0; m < 4; m++) for (int v = 0; v < 4; v++) begin
         wr_reg(8'hf8, {4'h2, v[1], 1'b0, v[0], 1'b0});
         smap = m[1:0]; isrc = v[0]; sev = ~v[0];
         repeat (3) @(negedge clk);
         e = ~(((m == 0) ? v[0] : (m == 1) ? ~v[0] : (m == 2) ? v[0] : 1'b0) ^ v[1]);
         `CHK(sync_oe, e)
      end
      $display("test sync pin done");
      // Both pins inputs; host drives levels, trigger picks a pin
      wr_reg(8'hf8, 8'h24); tsel = 0;
      @(negedge clk); hp_sync = 1;
      @(negedge clk); `CHK(sl, 1'b1)
      repeat (3) @(negedge clk);
      `CHK(sl, 1'b0)
      `CHK(trig, 1'b0)
      tsel = 1; repeat (3) @(negedge clk); `CHK(trig, 1'b1)
      rd_reg(8'hf8, rdv); `CHK(rdv, 8'h34)
      hp_irq = 1; repeat (4) @(negedge clk);
      `CHK(trig, 1'b0)
      `CHK(il, 1'b0)
      rd_reg(8'hf8, rdv); `CHK(rdv, 8'h24)
      hp_irq = 0; hp_sync = 0;
      $display("test pin levels and trigger done");
      // Reset while the sync pin is pulled low must release it
      smap = 2'h0; wr_reg(8'hf8, 8'h00); `CHK(sync_oe, 1'b1)
      nrst = 0; @(negedge clk); `CHK(sync_oe, 1'b0)
      @(negedge clk); nrst = 1; repeat (3) @(negedge clk);
      rd_reg(8'hf8, rdv); `CHK(rdv, 8'h13)
      $display("test second reset done");
      give_verdict();
   end
endmodule
